// ==== common/pinirq_pkg.sv ====
// constants, state type and helper functions for the pin interrupt controller
package pinirq_pkg;
    // ==========================================
    // register offsets (byte address of word)
    localparam logic [5:0] OFS_CONTROL = 6'h00;
    localparam logic [5:0] OFS_EVENT = 6'h04;
    localparam logic [5:0] OFS_EN_CLR = 6'h08;
    localparam logic [5:0] OFS_EN_SET = 6'h0c;
    localparam logic [5:0] OFS_FLAGS = 6'h10;
    localparam logic [5:0] OFS_WAKE = 6'h14;
    localparam logic [5:0] OFS_CFG_A = 6'h18;
    localparam logic [5:0] OFS_CFG_B = 6'h1c;
    localparam logic [5:0] OFS_CFG_C = 6'h20;
    // ==========================================
    // field positions
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam int STATUS_BUSY_BIT = 7;
    localparam int NM_FILTER_BIT = 3;
    localparam int CFG_FILTER_BIT = 3;
    localparam int CFG_FIELD_W = 4;
    localparam int CFG_BITS = 96;
    // ==========================================
    // sense codes
    localparam logic [2:0] SENSE_NONE = 3'h0;
    localparam logic [2:0] SENSE_RISE = 3'h1;
    localparam logic [2:0] SENSE_FALL = 3'h2;
    localparam logic [2:0] SENSE_BOTH = 3'h3;
    localparam logic [2:0] SENSE_HIGH = 3'h4;
    localparam logic [2:0] SENSE_LOW = 3'h5;
    // ==========================================
    // reset values and timing
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic ctrl_enable;
        logic ctrl_reset;
        logic enabled;
        logic nm_filter;
        logic [2:0] nm_sense;
        logic nm_flag;
        logic nm_irq;
        logic wake;
        logic [31:0] evt_en;
        logic [31:0] irq_en;
        logic [31:0] flags;
        logic [31:0] wake_en;
        logic [31:0] owned;
        logic [31:0] sel_b;
        logic [31:0] irq;
        logic [31:0] event_out;
        logic [31:0] rdata;
        logic [CFG_BITS-1:0] cfg;
    } pinirq_state_t;

    function automatic logic pinirq_maj(input logic a, input logic b, input logic c);
        pinirq_maj = (a & b) | (a & c) | (b & c);
    endfunction : pinirq_maj

    function automatic logic pinirq_hits(input logic [2:0] sense, input logic cur,
                                         input logic prev);
        // [RQ21] sense code decode
        case (sense)
            SENSE_RISE: pinirq_hits = cur & ~prev;
            SENSE_FALL: pinirq_hits = ~cur & prev;
            SENSE_BOTH: pinirq_hits = cur ^ prev;
            SENSE_HIGH: pinirq_hits = cur;
            SENSE_LOW: pinirq_hits = ~cur;
            // [RQ25] reserved codes detect nothing
            default: pinirq_hits = 1'b0;
        endcase
    endfunction : pinirq_hits

    function automatic logic [31:0] pinirq_merge(input logic [31:0] old,
                                                 input logic [31:0] wd,
                                                 input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        pinirq_merge = (old & ~m) | (wd & m);
    endfunction : pinirq_merge
endpackage : pinirq_pkg

// ==== verilog/pinirq_detect.sv ====
// per-pin sampler, optional majority filter and sense detector
`timescale 1ns/1ps
module pinirq_detect (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_soft_clr,
    input wire logic i_pin,
    input wire logic i_filter_en,
    input wire logic [2:0] i_sense,
    output logic o_hit
);
    typedef struct packed {
        logic [2:0] smp;
        logic prev;
        logic hit;
    } pinirq_det_t;

    pinirq_det_t r;
    pinirq_det_t next_r;
    logic filt;

    always_comb begin
        next_r = r;
        // [RQ23] majority of three
        filt = i_filter_en ? pinirq_pkg::pinirq_maj(r.smp[0], r.smp[1], r.smp[2]) : r.smp[0];
        next_r.smp = {r.smp[1:0], i_pin};
        next_r.prev = filt;
        // [RQ24] edge vs level
        next_r.hit = pinirq_pkg::pinirq_hits(i_sense, filt, r.prev);
        if (i_soft_clr) begin
            next_r = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_hit = r.hit;
endmodule : pinirq_detect

// ==== verilog/pinirq_sync.sv ====
// busy tracker for control writes crossing into the peripheral side
`timescale 1ns/1ps
module pinirq_sync #(
    parameter int STAGES = pinirq_pkg::SYNC_STAGES
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    typedef enum logic {S_IDLE, S_RUN} pinirq_sst_t;
    typedef struct packed {
        pinirq_sst_t st;
        logic [3:0] cnt;
        logic done;
    } pinirq_sync_t;

    pinirq_sync_t r;
    pinirq_sync_t next_r;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        case (r.st)
            S_IDLE: begin
                if (i_start) begin
                    next_r.st = S_RUN;
                    next_r.cnt = 4'(STAGES - 1);
                end
            end
            S_RUN: begin
                if (r.cnt == 4'h0) begin
                    next_r.st = S_IDLE;
                    next_r.done = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            default: next_r.st = S_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= '{st: S_IDLE, cnt: 4'h0, done: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign o_busy = (r.st == S_RUN);
    assign o_done = r.done;
endmodule : pinirq_sync

// ==== verilog/pinirq_ctl.sv ====
// pin interrupt controller: flags, enables, events, wake and register port
// What this block and its host must do
// [RQ1] nonmask sense set only in own register
// [RQ2] nonmask filter bit turns on majority vote
// [RQ3] nonmask detection ignores global enable
// [RQ4] nonmask flag always requests, never masked
// [RQ5] each source owns one flag
// [RQ6] enable set/clear by writing ones
// [RQ7] request equals flag and enable
// [RQ8] request holds until flag/enable cleared
// [RQ9] one request per line plus nonmask
// [RQ10] first programmed pin owns shared line
// [RQ11] event enable bit gates pin event
// [RQ12] event emitted for every enabled detection
// [RQ13] sleep wake only with wake enable
// [RQ14] software avoids wake without irq enable
// [RQ15] synchronised write sets busy at once
// [RQ16] write during busy stalls then completes
// [RQ17] enable and soft reset are synchronised
// [RQ18] processor must enable interrupts globally
// [RQ19] handler reads flag registers for cause
// [RQ20] host enables a clock for edges
// [RQ21] nonmask sense code decode table
// [RQ22] nonmask flag cleared by writing one
// [RQ23] filter passes two-of-three sample value
// [RQ24] level re-sets flag, edge needs new edge
// [RQ25] reserved sense codes detect nothing
`timescale 1ns/1ps
module pinirq_ctl #(
    parameter int NPINS = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [5:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [3:0] i_be,
    input wire logic [31:0] i_wdata,
    input wire logic [NPINS-1:0] i_pin_a,
    input wire logic [NPINS-1:0] i_pin_b,
    input wire logic [NPINS-1:0] i_route_a,
    input wire logic [NPINS-1:0] i_route_b,
    input wire logic i_nm_pin,
    input wire logic i_sleep,
    output logic [31:0] o_rdata,
    output logic o_stall,
    output logic [NPINS-1:0] o_irq,
    output logic o_nm_irq,
    output logic [NPINS-1:0] o_event,
    output logic o_wake
);
    pinirq_pkg::pinirq_state_t r;
    pinirq_pkg::pinirq_state_t next_r;
    logic [NPINS-1:0] pin_src;
    logic [NPINS-1:0] pin_hit;
    logic [31:0] ext_hit;
    logic [31:0] pmask;
    logic nm_hit;
    logic sync_busy;
    logic sync_done;
    logic sync_start;
    logic soft_clr;
    logic ctrl_wr;
    logic wr_ok;
    logic [31:0] wm;

    assign pmask = 32'((64'h1 << NPINS) - 64'h1);
    assign soft_clr = sync_done & r.ctrl_reset;
    assign ctrl_wr = i_wr && (i_addr == pinirq_pkg::OFS_CONTROL) && i_be[0];
    // [RQ16] stall a control write while busy
    assign wr_ok = i_wr && !(ctrl_wr && sync_busy);
    assign sync_start = ctrl_wr && !sync_busy;
    assign wm = i_wdata & {{8{i_be[3]}}, {8{i_be[2]}}, {8{i_be[1]}}, {8{i_be[0]}}};

    // ==========================================
    // shared line ownership and detectors
    // [RQ10] owning pin selects source
    assign pin_src = (r.sel_b[NPINS-1:0] & i_pin_b) | (~r.sel_b[NPINS-1:0] & i_pin_a);

    for (genvar g = 0; g < NPINS; g++) begin : g_det
        pinirq_detect u_det (
            .i_clk(i_clk),
            .i_rst_b(i_rst_b),
            .i_soft_clr(soft_clr),
            .i_pin(pin_src[g]),
            .i_filter_en(r.cfg[g*pinirq_pkg::CFG_FIELD_W + pinirq_pkg::CFG_FILTER_BIT]),
            .i_sense(r.cfg[g*pinirq_pkg::CFG_FIELD_W +: 3]),
            .o_hit(pin_hit[g])
        );
    end

    // [RQ1] nonmask sense from its own register
    // [RQ2] nonmask filter bit selects vote
    pinirq_detect u_nm_det (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_soft_clr(soft_clr),
        .i_pin(i_nm_pin),
        .i_filter_en(r.nm_filter),
        .i_sense(r.nm_sense),
        .o_hit(nm_hit)
    );

    // [RQ17] enable and soft reset synchronised
    pinirq_sync u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_start(sync_start),
        .o_busy(sync_busy),
        .o_done(sync_done)
    );

    // ==========================================
    // next state
    always_comb begin
        next_r = r;
        ext_hit = 32'h0;
        ext_hit[NPINS-1:0] = pin_hit & r.owned[NPINS-1:0] & {NPINS{r.enabled}};
        for (int i = 0; i < NPINS; i++) begin
            if (!r.owned[i]) begin
                if (i_route_a[i] || i_route_b[i]) begin
                    next_r.owned[i] = 1'b1;
                    next_r.sel_b[i] = ~i_route_a[i];
                end
            end else if (r.sel_b[i] ? !i_route_b[i] : !i_route_a[i]) begin
                next_r.owned[i] = 1'b0;
            end
        end
        if (wr_ok) begin
            case (i_addr)
                pinirq_pkg::OFS_CONTROL: begin
                    if (i_be[0]) begin
                        // [RQ17] soft reset discards other bits
                        if (i_wdata[pinirq_pkg::CTRL_RESET_BIT]) begin
                            next_r.ctrl_reset = 1'b1;
                            next_r.ctrl_enable = 1'b0;
                        end else begin
                            next_r.ctrl_enable = i_wdata[pinirq_pkg::CTRL_ENABLE_BIT];
                        end
                    end
                    if (i_be[2]) begin
                        next_r.nm_filter = i_wdata[16 + pinirq_pkg::NM_FILTER_BIT];
                        next_r.nm_sense = i_wdata[18:16];
                    end
                    // [RQ22] write one clears nonmask flag
                    if (i_be[3] && i_wdata[24]) begin
                        next_r.nm_flag = 1'b0;
                    end
                end
                pinirq_pkg::OFS_EVENT: begin
                    // [RQ11] event output enables
                    next_r.evt_en = pinirq_pkg::pinirq_merge(r.evt_en, i_wdata, i_be) & pmask;
                end
                pinirq_pkg::OFS_EN_CLR: begin
                    // [RQ6] clear by ones
                    next_r.irq_en = r.irq_en & ~wm;
                end
                pinirq_pkg::OFS_EN_SET: begin
                    // [RQ6] set by ones
                    next_r.irq_en = (r.irq_en | wm) & pmask;
                end
                pinirq_pkg::OFS_FLAGS: begin
                    next_r.flags = r.flags & ~wm;
                end
                pinirq_pkg::OFS_WAKE: begin
                    next_r.wake_en = pinirq_pkg::pinirq_merge(r.wake_en, i_wdata, i_be) & pmask;
                end
                pinirq_pkg::OFS_CFG_A: begin
                    next_r.cfg[31:0] = pinirq_pkg::pinirq_merge(r.cfg[31:0], i_wdata, i_be);
                end
                pinirq_pkg::OFS_CFG_B: begin
                    next_r.cfg[63:32] = pinirq_pkg::pinirq_merge(r.cfg[63:32], i_wdata, i_be);
                end
                pinirq_pkg::OFS_CFG_C: begin
                    next_r.cfg[95:64] = pinirq_pkg::pinirq_merge(r.cfg[95:64], i_wdata, i_be);
                end
                default: begin
                end
            endcase
        end
        // [RQ5] flags set on detection, set wins
        next_r.flags = next_r.flags | ext_hit;
        // [RQ3] nonmask flag independent of enable
        next_r.nm_flag = next_r.nm_flag | nm_hit;
        if (sync_done) begin
            next_r.enabled = r.ctrl_enable;
        end
        // [RQ7] request is flag and enable
        next_r.irq = next_r.flags & next_r.irq_en;
        // [RQ4] nonmask request follows flag only
        next_r.nm_irq = next_r.nm_flag;
        // [RQ12] event per enabled detection
        next_r.event_out = ext_hit & r.evt_en;
        // [RQ13] wake only with wake enable
        next_r.wake = i_sleep && ((ext_hit & r.wake_en) != 32'h0);
        if (i_rd) begin
            case (i_addr)
                pinirq_pkg::OFS_CONTROL: begin
                    next_r.rdata = {7'h0, r.nm_flag, 4'h0, r.nm_filter, r.nm_sense,
                                    sync_busy, 7'h0, 6'h0, r.ctrl_enable, r.ctrl_reset};
                end
                pinirq_pkg::OFS_EVENT: next_r.rdata = r.evt_en;
                pinirq_pkg::OFS_EN_CLR: next_r.rdata = r.irq_en;
                pinirq_pkg::OFS_EN_SET: next_r.rdata = r.irq_en;
                pinirq_pkg::OFS_FLAGS: next_r.rdata = r.flags;
                pinirq_pkg::OFS_WAKE: next_r.rdata = r.wake_en;
                pinirq_pkg::OFS_CFG_A: next_r.rdata = r.cfg[31:0];
                pinirq_pkg::OFS_CFG_B: next_r.rdata = r.cfg[63:32];
                pinirq_pkg::OFS_CFG_C: next_r.rdata = r.cfg[95:64];
                default: next_r.rdata = pinirq_pkg::RESET_WORD;
            endcase
        end
        // [RQ17] soft reset returns all to reset state
        if (soft_clr) begin
            next_r = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================
    // outputs
    // [RQ9] one request per line plus nonmask
    assign o_irq = r.irq[NPINS-1:0];
    assign o_nm_irq = r.nm_irq;
    assign o_event = r.event_out[NPINS-1:0];
    assign o_wake = r.wake;
    assign o_rdata = r.rdata;
    // [RQ15] busy drives the stall
    assign o_stall = sync_busy;

    // ==========================================
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // [RQ7] request tracks flag
    irq_equals_flag_a: assert property ( // [RQ7]
        o_irq == (r.flags[NPINS-1:0] & r.irq_en[NPINS-1:0]))
        else $error("irq differs from flag and enable");

    // [RQ8] request holds
    irq_hold_a: assert property ( // [RQ8]
        $fell(o_irq[0]) |-> (!r.flags[0] || !r.irq_en[0] || $past(soft_clr)))
        else $error("irq dropped with flag and enable set");

    // [RQ4] nonmask hit requests
    nm_request_a: assert property ( // [RQ4]
        (nm_hit && !soft_clr) |=> (o_nm_irq && r.nm_flag))
        else $error("nonmask hit gave no request");

    // [RQ4] request follows flag
    nm_irq_flag_a: assert property ( // [RQ4]
        o_nm_irq == r.nm_flag)
        else $error("nonmask request differs from flag");

    // [RQ3] nonmask ignores enable
    nm_ungated_a: assert property ( // [RQ3]
        (nm_hit && !r.enabled && !soft_clr) |=> r.nm_flag)
        else $error("nonmask detection gated by enable");

    // [RQ22] write one clears
    nm_clear_a: assert property ( // [RQ22]
        (wr_ok && i_addr == pinirq_pkg::OFS_CONTROL && i_be[3] && i_wdata[24]
         && !nm_hit) |=> !r.nm_flag)
        else $error("nonmask flag not cleared");

    // [RQ6] set by ones
    en_set_a: assert property ( // [RQ6]
        (wr_ok && i_addr == pinirq_pkg::OFS_EN_SET && i_be[0] && i_wdata[0]
         && !soft_clr) |=> r.irq_en[0])
        else $error("enable set failed");

    // [RQ6] clear by ones
    en_clear_a: assert property ( // [RQ6]
        (wr_ok && i_addr == pinirq_pkg::OFS_EN_CLR && i_be[0] && i_wdata[0])
        |=> !r.irq_en[0])
        else $error("enable clear failed");

    // [RQ12] event needs detection
    event_gate_a: assert property ( // [RQ12]
        o_event[0] |-> ($past(pin_hit[0]) && $past(r.evt_en[0]) && $past(r.enabled)))
        else $error("event without enabled detection");

    // [RQ11] enabled event emitted
    event_emit_a: assert property ( // [RQ11]
        (ext_hit[0] && r.evt_en[0] && !soft_clr) |=> o_event[0])
        else $error("enabled detection gave no event");

    // [RQ13] wake needs enable
    wake_gate_a: assert property ( // [RQ13]
        o_wake |-> ($past(i_sleep) && ($past(ext_hit & r.wake_en) != 32'h0)))
        else $error("wake without enabled pin");

    // [RQ13] enabled hit wakes
    wake_emit_a: assert property ( // [RQ13]
        (i_sleep && ((ext_hit & r.wake_en) != 32'h0) && !soft_clr) |=> o_wake)
        else $error("enabled pin gave no wake");

    // [RQ15] busy length
    busy_set_a: assert property ( // [RQ15]
        sync_start |=> o_stall [*2] ##1 !o_stall)
        else $error("busy timing wrong");

    // [RQ15] busy set at once
    busy_start_a: assert property ( // [RQ15]
        (ctrl_wr && !o_stall) |=> o_stall)
        else $error("busy not set by control write");

    // [RQ16] stall holds control
    stall_hold_a: assert property ( // [RQ16]
        (ctrl_wr && sync_busy) |=> $stable(r.ctrl_enable))
        else $error("control changed during stall");

    // [RQ17] enable applied after sync
    enable_sync_a: assert property ( // [RQ17]
        sync_done |=> (r.enabled == $past(r.ctrl_enable)))
        else $error("enable not applied after sync");

    // [RQ17] soft reset clears state
    soft_reset_a: assert property ( // [RQ17]
        soft_clr |=> (r.irq_en == 32'h0 && !r.enabled && !r.nm_flag))
        else $error("soft reset left state");

    // [RQ5] detection sets flag
    flag_set_a: assert property ( // [RQ5]
        (ext_hit[0] && !soft_clr) |=> r.flags[0])
        else $error("detection set no flag");

    // [RQ10] owner kept while routed
    owner_keep_a: assert property ( // [RQ10]
        (r.owned[0] && !soft_clr && (r.sel_b[0] ? i_route_b[0] : i_route_a[0]))
        |=> (r.owned[0] && $stable(r.sel_b[0])))
        else $error("shared line owner changed");

    // [RQ25] reserved nonmask code
    reserved_none_a: assert property ( // [RQ25]
        (r.nm_sense > pinirq_pkg::SENSE_LOW) [*3] |-> !nm_hit)
        else $error("reserved sense detected");

    // [RQ25] reserved pin code
    pin_reserved_a: assert property ( // [RQ25]
        (r.cfg[2:0] > pinirq_pkg::SENSE_LOW) [*3] |-> !pin_hit[0])
        else $error("reserved pin sense detected");
endmodule : pinirq_ctl

// ==== sim/pinirq_host_model.sv ====
// far-side model: interrupt controller and event system watching the block
`timescale 1ns/1ps
module pinirq_host_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_glob_irq_on,
    input wire logic [15:0] i_irq,
    input wire logic i_nm_irq,
    input wire logic [15:0] i_event,
    output logic [15:0] o_evt_cnt,
    output logic o_pending
);
    // ==========================================
    // event system: one count per pulse
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_evt_cnt <= 16'h0000;
        end else begin
            o_evt_cnt <= o_evt_cnt + 16'($countones(i_event));
        end
    end
    // ==========================================
    // processor side: maskable lines need the global switch
    // global interrupt switch
    assign o_pending = i_nm_irq | (i_glob_irq_on & (|i_irq));
endmodule : pinirq_host_model

// ==== sim/pinirq_ctl_tb_top.sv ====
// self-checking bench for the pin interrupt controller
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module pinirq_ctl_tb_top;
    logic i_clk, i_rst_b, i_wr, i_rd, i_nm_pin, i_sleep, o_stall, o_nm_irq, o_wake, pend;
    logic [5:0] i_addr;
    logic [3:0] i_be;
    logic [31:0] i_wdata, o_rdata, rv;
    logic [15:0] i_pin_a, i_pin_b, i_route_a, i_route_b, o_irq, o_event, evt_cnt;
    int error_cnt = 0;
    int total_checks = 0;
    // ==========================================
    // clock, design and far side
    // clock runs before edge detection is used
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    pinirq_ctl i_pinirq_ctl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr),
        .i_rd(i_rd), .i_be(i_be), .i_wdata(i_wdata), .i_pin_a(i_pin_a), .i_pin_b(i_pin_b),
        .i_route_a(i_route_a), .i_route_b(i_route_b), .i_nm_pin(i_nm_pin), .i_sleep(i_sleep),
        .o_rdata(o_rdata), .o_stall(o_stall), .o_irq(o_irq), .o_nm_irq(o_nm_irq),
        .o_event(o_event), .o_wake(o_wake));
    pinirq_host_model i_pinirq_host_model (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_glob_irq_on(1'b1), .i_irq(o_irq), .i_nm_irq(o_nm_irq), .i_event(o_event),
        .o_evt_cnt(evt_cnt), .o_pending(pend));
    // ==========================================
    // bus tasks
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        logic st;
        int n;
        @(posedge i_clk);
        i_addr <= a;
        i_be <= be;
        i_wdata <= d;
        i_wr <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(negedge i_clk);
            st = o_stall & (a == 6'h00) & be[0];
            @(posedge i_clk);
            if (!st) break;
        end
        i_wr <= 1'b0;
        if (n == 20) begin
            error_cnt++;
            wrap_up();
        end
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    task automatic wait_idle();
        int n;
        for (n = 0; n < 20 && o_stall !== 1'b0; n++) @(negedge i_clk);
        if (n == 20) begin
            error_cnt++;
            wrap_up();
        end
    endtask : wait_idle
    // ==========================================
    // scenarios
    task automatic t_reset_vals();
        logic [5:0] ofs [7] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18};
        foreach (ofs[k]) begin
            rd(ofs[k], rv);
            `CHK(rv, pinirq_pkg::RESET_WORD) // reset value
        end
        rd(6'h3c, rv);
        `CHK(rv, 32'h0000_0000) // unmapped reads zero
    endtask : t_reset_vals
    task automatic t_nonmask();
        wr(6'h00, 4'h4, {8'h00, 5'h00, pinirq_pkg::SENSE_RISE, 16'h0000});
        i_nm_pin <= 1'b1;
        cyc(5);
        `CHK(o_nm_irq, 1'b1)
        rd(6'h00, rv);
        `CHK(rv[24], 1'b1)
        wr(6'h00, 4'h8, 32'h0000_0000);
        cyc(2);
        `CHK(o_nm_irq, 1'b1)
        wr(6'h00, 4'h8, 32'h0100_0000);
        cyc(2);
        `CHK(o_nm_irq, 1'b0)
        i_nm_pin <= 1'b0;
        wr(6'h00, 4'h4, 32'h0006_0000);
        i_nm_pin <= 1'b1;
        cyc(6);
        `CHK(o_nm_irq, 1'b0)
        i_nm_pin <= 1'b0;
        wr(6'h00, 4'h4, 32'h000c_0000);
        @(posedge i_clk) i_nm_pin <= 1'b1;
        @(posedge i_clk) i_nm_pin <= 1'b0;
        cyc(8);
        `CHK(o_nm_irq, 1'b0)
        wr(6'h00, 4'h4, 32'h0004_0000);
        @(posedge i_clk) i_nm_pin <= 1'b1;
        @(posedge i_clk) i_nm_pin <= 1'b0;
        cyc(5);
        `CHK(o_nm_irq, 1'b1)
        wr(6'h00, 4'hc, 32'h0100_0000);
        cyc(2);
        `CHK(o_nm_irq, 1'b0)
    endtask : t_nonmask
    task automatic t_enable();
        wr(6'h00, 4'h1, 32'h0000_0002);
        @(negedge i_clk);
        `CHK(o_stall, 1'b1)
        wr(6'h00, 4'h1, 32'h0000_0002);
        rd(6'h00, rv);
        `CHK(rv[1], 1'b1)
        wait_idle();
        wr(6'h0c, 4'hf, 32'h0000_0007);
        wr(6'h08, 4'hf, 32'h0000_0005);
        rd(6'h0c, rv);
        `CHK(rv, 32'h0000_0002)
        wr(6'h0c, 4'hf, 32'h0000_0007);
        rd(6'h08, rv);
        `CHK(rv, 32'h0000_0007)
    endtask : t_enable
    task automatic t_edge_level();
        wr(6'h18, 4'hf, 32'h0000_0141);
        wr(6'h04, 4'hf, 32'h0000_0001);
        i_route_a <= 16'h0003;
        i_pin_a <= 16'h0001;
        cyc(5);
        `CHK(o_irq[0], 1'b1)
        `CHK(evt_cnt, 16'h0001)
        `CHK(pend, 1'b1)
        rd(6'h10, rv);
        `CHK(rv[0], 1'b1)
        wr(6'h10, 4'hf, 32'h0000_0001);
        cyc(5);
        `CHK(o_irq[0], 1'b0)
        i_pin_a <= 16'h0003;
        cyc(5);
        `CHK(o_irq[1], 1'b1)
        `CHK(evt_cnt, 16'h0001)
        wr(6'h10, 4'hf, 32'h0000_0002);
        cyc(3);
        `CHK(o_irq[1], 1'b1)
        wr(6'h08, 4'hf, 32'h0000_0002);
        cyc(2);
        `CHK(o_irq[1], 1'b0)
    endtask : t_edge_level
    task automatic t_shared();
        @(posedge i_clk) i_route_a <= 16'h0007;
        @(posedge i_clk) i_route_b <= 16'h0004;
        i_pin_b <= 16'h0004;
        cyc(6);
        `CHK(o_irq[2], 1'b0)
        i_pin_a <= 16'h0007;
        cyc(6);
        `CHK(o_irq[2], 1'b1)
    endtask : t_shared
    task automatic t_wake();
        // irq enable set before wake enable
        wr(6'h0c, 4'hf, 32'h0000_0002);
        i_sleep <= 1'b1;
        cyc(4);
        `CHK(o_wake, 1'b0)
        wr(6'h14, 4'hf, 32'h0000_0002);
        cyc(4);
        `CHK(o_wake, 1'b1)
        wr(6'h14, 4'hf, 32'h0000_0000);
        cyc(4);
        `CHK(o_wake, 1'b0)
        i_sleep <= 1'b0;
    endtask : t_wake
    task automatic t_soft_reset();
        wr(6'h00, 4'h1, 32'h0000_0001);
        cyc(1);
        wait_idle();
        rd(6'h0c, rv);
        `CHK(rv, 32'h0000_0000)
        rd(6'h00, rv);
        `CHK(rv, 32'h0000_0000)
    endtask : t_soft_reset
    // ==========================================
    // main sequence
    initial begin
        i_rst_b = 1'b0;
        {i_wr, i_rd, i_nm_pin, i_sleep} = 4'h0;
        i_addr = 6'h00;
        i_be = 4'h0;
        i_wdata = 32'h0000_0000;
        {i_pin_a, i_pin_b, i_route_a, i_route_b} = 64'h0;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_reset_vals();
        t_nonmask();
        t_enable();
        t_edge_level();
        t_shared();
        t_wake();
        t_soft_reset();
        wrap_up();
    end
endmodule : pinirq_ctl_tb_top
